// File: logic/fpu_exc_regs.svh
// Constants for the FPU exception control and status register
// Functional notes
// - Five cause bits sit in bits 16..12, ordered invalid, divide-by-zero, overflow, underflow, inexact.
// - Five trap-enable bits sit in bits 11..7 in the same condition order.
// - Each enable bit alone decides whether its own condition traps.
// - A trap is taken when an arithmetic operation sets a cause bit whose enable bit is set.
// - A trap is also taken when software writes the register with an enable and matching cause both set, if no operation completes in that cycle.
// - Five sticky flag bits in bits 6..2 accumulate conditions of completed instructions until software clears them.
// - The flag bits use the same order, bit 6 invalid down to bit 2 inexact.
// - Bits 1..0 select rounding: 00 nearest, 01 toward zero, 10 toward plus infinity, 11 toward minus infinity.
`ifndef FPU_EXC_REGS_SVH
`define FPU_EXC_REGS_SVH
`define CAUSE_HI     16
`define CAUSE_LO     12
`define ENABLE_HI    11
`define ENABLE_LO    7
`define FLAG_HI      6
`define FLAG_LO      2
`define ROUND_HI     1
`define ROUND_LO     0
`define CSR_RESET    32'h00000000
`define CSR_WMASK    32'h0001ffff
`endif

// File: logic/fpu_exc_pkg.sv
// Types for the FPU exception control and status logic
package fpu_exc_pkg;
  typedef enum logic [1:0] {
    ROUND_NEAREST,
    ROUND_ZERO,
    ROUND_PLUS_INF,
    ROUND_MINUS_INF
  } rounding_select_type;
endpackage

// File: logic/fpu_exception_control_status.sv
// FPU exception cause, enable, flag and rounding control register
`timescale 1ns/10ps
`include "fpu_exc_regs.svh"
module fpu_exception_control_status (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic                              csrWrite,
  input  wire logic [31:0]                       csrWriteData,
  output logic      [31:0]                       csrReadData,
  input  wire logic                              opDone,
  input  wire logic [4:0]                        opExceptions,
  output fpu_exc_pkg::rounding_select_type       roundingSelect,
  output logic                                   trap
);

  // Number of exception conditions
  localparam int CONDITIONS = 5;

  // Register fields
  logic [4:0]                        cause_reg;
  logic [4:0]                        trapEnableGroup_reg;
  logic [4:0]                        flag_reg;
  logic [1:0]                        round_reg;

  // Next values
  logic [4:0]                        cause_next;
  logic [4:0]                        enable_next;
  logic [4:0]                        flag_next;
  logic [1:0]                        round_next;
  logic                              trap_next;
  logic [31:0]                       image_next;
  fpu_exc_pkg::rounding_select_type  roundMode_next;

  // Write data split into fields
  logic [31:0]                       writeMasked;
  logic [4:0]                        writeCause;
  logic [4:0]                        writeEnable;
  logic [4:0]                        writeFlags;
  logic [1:0]                        writeRound;

  // Trap qualifiers
  logic [4:0]                        opResult;
  logic [4:0]                        trapHit;
  logic                              trapEvent;

  // Upper bits ignored on write
  assign writeMasked = csrWriteData & `CSR_WMASK;

  // Fields of the written value
  assign writeCause  = writeMasked[`CAUSE_HI:`CAUSE_LO];
  assign writeEnable = writeMasked[`ENABLE_HI:`ENABLE_LO];
  assign writeFlags  = writeMasked[`FLAG_HI:`FLAG_LO];
  assign writeRound  = writeMasked[`ROUND_HI:`ROUND_LO];

  // Conditions of a completed operation
  always_comb begin
    opResult = 5'h00;
    if (opDone) begin
      opResult = opExceptions;
    end
  end

  // One slice per exception condition
  for (genvar i = 0; i < CONDITIONS; i++) begin : gen_condition
    logic causeBit;
    logic enableBit;
    logic flagBit;
    logic hitBit;

    // Cause: an operation result overrides a written value
    always_comb begin
      causeBit = cause_reg[i];
      if (csrWrite) begin
        causeBit = writeCause[i];
      end
      if (opDone) begin
        causeBit = opExceptions[i];
      end
    end

    // Enable: loaded only by software
    always_comb begin
      enableBit = trapEnableGroup_reg[i];
      if (csrWrite) begin
        enableBit = writeEnable[i];
      end
    end

    // Flag: set wins over software clear
    always_comb begin
      flagBit = flag_reg[i];
      if (csrWrite) begin
        flagBit = writeFlags[i];
      end
      if (opResult[i]) begin
        flagBit = 1'b1;
      end
    end

    // Hit: this condition alone decides its own trap
    always_comb begin
      hitBit = causeBit & enableBit;
    end

    assign cause_next[i]  = causeBit;
    assign enable_next[i] = enableBit;
    assign flag_next[i]   = flagBit;
    assign trapHit[i]     = hitBit;
  end

  // Rounding: loaded only by software
  always_comb begin
    round_next = round_reg;
    if (csrWrite) begin
      round_next = writeRound;
    end
  end

  // Rounding encoding to the datapath
  always_comb begin
    roundMode_next = fpu_exc_pkg::ROUND_NEAREST;
    unique case (round_next)
      2'h0: roundMode_next = fpu_exc_pkg::ROUND_NEAREST;
      2'h1: roundMode_next = fpu_exc_pkg::ROUND_ZERO;
      2'h2: roundMode_next = fpu_exc_pkg::ROUND_PLUS_INF;
      2'h3: roundMode_next = fpu_exc_pkg::ROUND_MINUS_INF;
    endcase
  end

  // Trap event: a completed operation or a software write
  always_comb begin
    trapEvent = opDone | csrWrite;
  end

  // Trap: evaluated on the causes of this edge
  always_comb begin
    trap_next = 1'b0;
    if (trapEvent) begin
      trap_next = |trapHit;
    end
  end

  // Read image: value after this edge's update
  always_comb begin
    image_next = `CSR_RESET;
    image_next[31:17] = 15'h0000;
    image_next[`CAUSE_HI:`CAUSE_LO]   = cause_next;
    image_next[`ENABLE_HI:`ENABLE_LO] = enable_next;
    image_next[`FLAG_HI:`FLAG_LO]     = flag_next;
    image_next[`ROUND_HI:`ROUND_LO]   = round_next;
  end

  // Cause bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cause_reg <= 5'h00;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Trap enable bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trapEnableGroup_reg <= 5'h00;
    end else begin
      trapEnableGroup_reg <= enable_next;
    end
  end

  // Sticky flag bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= 5'h00;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Rounding field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      round_reg <= 2'h0;
    end else begin
      round_reg <= round_next;
    end
  end

  // Rounding selection to the datapath
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      roundingSelect <= fpu_exc_pkg::ROUND_NEAREST;
    end else begin
      roundingSelect <= roundMode_next;
    end
  end

  // Trap pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trap <= 1'b0;
    end else begin
      trap <= trap_next;
    end
  end

  // Read image
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csrReadData <= `CSR_RESET;
    end else begin
      csrReadData <= image_next;
    end
  end
endmodule

// File: verification/fpu_exc_checker.sv
// Checker for the FPU exception register
`timescale 1ns/10ps
module fpu_exc_checker (
  input logic                             clk,
  input logic                             resetn,
  input logic                             csrWrite,
  input logic                             opDone,
  input logic                             trap,
  input logic [31:0]                      csrWriteData,
  input logic [31:0]                      csrReadData,
  input logic [4:0]                       opExceptions,
  input fpu_exc_pkg::rounding_select_type roundingSelect
);
  wire [31:0] rd = csrReadData;
  wire [31:0] wd = csrWriteData;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_wr_cause: assert property (csrWrite && !opDone |=> rd[16:12] == $past(wd[16:12]))
    else $error("cause write");
  chk_wr_enable: assert property (csrWrite |=> rd[11:7] == $past(wd[11:7]))
    else $error("enable write");
  chk_op_cause: assert property (opDone |=> rd[16:12] == $past(opExceptions))
    else $error("op cause");
  chk_flag_sticky: assert property (opDone && !csrWrite |=> rd[6:2] == $past(rd[6:2] | opExceptions))
    else $error("flags");
  chk_round_map: assert property (roundingSelect == rd[1:0])
    else $error("rounding");
  chk_trap_cause: assert property (trap |-> |(rd[16:12] & rd[11:7]))
    else $error("stray trap");
  chk_trap_write: assert property (csrWrite && !opDone && |(wd[16:12] & wd[11:7]) |=> trap)
    else $error("write trap");
  chk_trap_op: assert property (opDone |=> trap == |($past(opExceptions) & rd[11:7]))
    else $error("op trap");
endmodule
bind fpu_exception_control_status fpu_exc_checker chk (.*);

// File: verification/core_model.sv
// Core model issuing completed operations
`timescale 1ns/10ps
module core_model (
  input  logic       clk,
  input  logic       go,
  input  logic [4:0] exc,
  output logic       opDone = 1'h0,
  output logic [4:0] opExceptions = 5'h00
);
  always @(posedge clk) begin
    opDone <= #1 go;
    opExceptions <= #1 go ? exc : ~opExceptions;
  end
endmodule

// File: verification/test_fpu_exception_control_status.sv
// Testbench for the FPU exception register
`timescale 1ns/10ps
module test_fpu_exception_control_status;
  logic clk = 1'h0, resetn = 1'h0, csrWrite = 1'h0, go = 1'h0, trap, opDone;
  logic [31:0] csrWriteData = 32'h0, csrReadData;
  logic [4:0] exc = 5'h00, opExceptions;
  fpu_exc_pkg::rounding_select_type roundingSelect;
  int failCount = 0, samplesChecked = 0, cyc = 0;
  always #5 clk = ~clk;
  core_model core (.*);
  fpu_exception_control_status uut (.*);
  task wrapUp;
    $display("checks %0d fails %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task s(input logic [1:0] wg, input logic [31:0] d, input logic [4:0] e,
    input logic [31:0] er, input logic et);
    @(posedge clk) #1 go = wg[0];
    exc = e;
    @(posedge clk) #1 go = 1'h0;
    csrWrite = wg[1];
    csrWriteData = d;
    @(posedge clk) #1 csrWrite = 1'h0;
    samplesChecked++;
    if (csrReadData !== er || trap !== et) begin
      failCount++;
      $display("[FAIL] %0t reg %h", $time, csrReadData);
    end
    if (roundingSelect !== er[1:0]) begin
      failCount++;
      $display("[FAIL] %0t rounding %h", $time, roundingSelect);
    end
    $display("test %0d done", samplesChecked);
  endtask
  always @(posedge clk) if (++cyc > 100) begin
    failCount++;
    wrapUp();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 resetn = 1'h1;
    s(2'h0, 32'h0, 5'h00, 32'h0, 1'h0);
    s(2'h2, 32'h10800, 5'h00, 32'h10800, 1'h1);
    s(2'h2, 32'hfffe0fff, 5'h00, 32'h00fff, 1'h0);
    s(2'h1, 32'h0, 5'h01, 32'h01fff, 1'h1);
    s(2'h2, 32'h00101, 5'h00, 32'h00101, 1'h0);
    s(2'h1, 32'h0, 5'h10, 32'h10141, 1'h0);
    s(2'h1, 32'h0, 5'h02, 32'h02149, 1'h1);
    s(2'h3, 32'h00002, 5'h04, 32'h04012, 1'h0);
    wrapUp();
  end
endmodule
